// [shared/shift_unit_pkg.sv]
// How it works
// RULE1 - Register left shift moves first input left by second input's low five bits, zero fill.
// RULE2 - Immediate left shift moves first input left by the instruction's five-bit count.
// RULE3 - Arithmetic right shift treats first input as signed, replicates sign into vacated bits.
// RULE4 - Arithmetic right shift ignores bits 31 down to 5 of the count register.
// RULE5 - Register left shift: R-format, extended opcode 0x13, bits 10..6 zero, opcode 0x3a.
// RULE6 - Immediate left shift: R-format, B field zero, extended opcode 0x12, count in 10..6.
// RULE7 - Arithmetic right shift: R-format, extended opcode 0x3b, bits 10..6 zero, opcode 0x3a.
// RULE8 - No shift raises an exception; register left shift ignores upper 27 count bits.
package shift_unit_pkg;
  localparam int DATA_W = 32;
  localparam int COUNT_W = 5;
  localparam int INDEX_W = 5;
  localparam int A_LSB = 27;
  localparam int B_LSB = 22;
  localparam int C_LSB = 17;
  localparam int OPX_LSB = 11;
  localparam int SHAMT_LSB = 6;
  localparam int OP_LSB = 0;
  localparam logic [5:0] OP_RTYPE = 6'h3A;
  localparam logic [5:0] OPX_SHL_REG = 6'h13;
  localparam logic [5:0] OPX_SHL_IMM = 6'h12;
  localparam logic [5:0] OPX_SRA_REG = 6'h3B;
  localparam logic [DATA_W-1:0] RESULT_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    SHIFT_NONE = 2'b00,
    SHIFT_LEFT_REG = 2'b01,
    SHIFT_LEFT_IMM = 2'b11,
    SHIFT_RIGHT_ARITH = 2'b10
  } shift_op_t;

  typedef struct packed {
    logic valid;
    logic [INDEX_W-1:0] dest_index;
    logic [DATA_W-1:0] value;
  } shift_result_t;
endpackage : shift_unit_pkg

// [design/shift_left_and_arith_right_unit.sv]
`timescale 1ns/100ps
`default_nettype none
module shift_left_and_arith_right_unit (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic issue_in,
  input wire logic [31:0] instr_in,
  input wire logic [shift_unit_pkg::DATA_W-1:0] first_input,
  input wire logic [shift_unit_pkg::DATA_W-1:0] second_input,
  output var shift_unit_pkg::shift_result_t dest_out,
  output logic accepted_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode helper shared by the three instruction checks.
  function automatic shift_unit_pkg::shift_op_t decode_shift(input logic [31:0] w);
    logic [5:0] opx;
    logic [4:0] mid;
    logic [4:0] bidx;
    opx = w[shift_unit_pkg::OPX_LSB +: 6];
    mid = w[shift_unit_pkg::SHAMT_LSB +: 5];
    bidx = w[shift_unit_pkg::B_LSB +: 5];
    decode_shift = shift_unit_pkg::SHIFT_NONE;
    if (w[shift_unit_pkg::OP_LSB +: 6] == shift_unit_pkg::OP_RTYPE) begin
      if (opx == shift_unit_pkg::OPX_SHL_REG && mid == 5'h00) begin
        decode_shift = shift_unit_pkg::SHIFT_LEFT_REG; // RULE5
      end else if (opx == shift_unit_pkg::OPX_SHL_IMM && bidx == 5'h00) begin
        decode_shift = shift_unit_pkg::SHIFT_LEFT_IMM; // RULE6
      end else if (opx == shift_unit_pkg::OPX_SRA_REG && mid == 5'h00) begin
        decode_shift = shift_unit_pkg::SHIFT_RIGHT_ARITH; // RULE7
      end
    end
  endfunction : decode_shift

  ////////////////////////////////////////////////////////////////////////////////
  shift_unit_pkg::shift_op_t op;
  logic [shift_unit_pkg::COUNT_W-1:0] count;
  logic [shift_unit_pkg::DATA_W-1:0] next_value;
  logic result_valid;
  logic [shift_unit_pkg::INDEX_W-1:0] result_index;
  logic [shift_unit_pkg::DATA_W-1:0] result_value;
  logic [shift_unit_pkg::DATA_W-1:0] left_stage [0:shift_unit_pkg::COUNT_W];
  logic [shift_unit_pkg::DATA_W-1:0] right_stage [0:shift_unit_pkg::COUNT_W];

  ////////////////////////////////////////////////////////////////////////////////
  // Five stages, each moving by a power of two, keep the shifter a shallow mux tree
  // instead of one wide variable shift; both directions share the same count bits.
  assign left_stage[0] = first_input;
  assign right_stage[0] = first_input;

  for (genvar k = 0; k < shift_unit_pkg::COUNT_W; k++) begin : g_stage
    localparam int STEP = 1 << k;
    assign left_stage[k + 1] = count[k] ?
      {left_stage[k][shift_unit_pkg::DATA_W-1-STEP:0], {STEP{1'b0}}} : left_stage[k]; // RULE1 RULE2
    assign right_stage[k + 1] = count[k] ?
      {{STEP{right_stage[k][shift_unit_pkg::DATA_W-1]}}, right_stage[k][shift_unit_pkg::DATA_W-1:STEP]} :
      right_stage[k]; // RULE3
  end

  assign op = decode_shift(instr_in);
  assign accepted_out = issue_in && (op != shift_unit_pkg::SHIFT_NONE);

  // Only the low five bits of the count register matter; no out-of-range case exists,
  // so there is nothing to flag as an exception.
  always_comb begin
    case (op)
      shift_unit_pkg::SHIFT_LEFT_IMM: count = instr_in[shift_unit_pkg::SHAMT_LSB +: 5]; // RULE2
      default: count = second_input[shift_unit_pkg::COUNT_W-1:0]; // RULE4 RULE8
    endcase
  end

  always_comb begin
    case (op)
      shift_unit_pkg::SHIFT_LEFT_REG,
      shift_unit_pkg::SHIFT_LEFT_IMM: next_value = left_stage[shift_unit_pkg::COUNT_W]; // RULE1 RULE2
      shift_unit_pkg::SHIFT_RIGHT_ARITH: next_value = right_stage[shift_unit_pkg::COUNT_W]; // RULE3
      default: next_value = shift_unit_pkg::RESULT_RESET;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      result_valid <= 1'b0;
    end else begin
      result_valid <= accepted_out;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      result_index <= 5'h00;
      result_value <= shift_unit_pkg::RESULT_RESET;
    end else if (accepted_out) begin
      result_index <= instr_in[shift_unit_pkg::C_LSB +: 5];
      result_value <= next_value;
    end
  end

  // The result port is a view of the three registers above.
  assign dest_out = '{valid: result_valid, dest_index: result_index, value: result_value};

  ////////////////////////////////////////////////////////////////////////////////
  a_shl_reg_result: assert property (@(posedge clk_in) disable iff (rst_in) // RULE1
    issue_in && op == shift_unit_pkg::SHIFT_LEFT_REG |=>
      dest_out.value == ($past(first_input) << $past(second_input[4:0])))
    else $error("Register left shift result wrong.");
  a_shl_imm_result: assert property (@(posedge clk_in) disable iff (rst_in) // RULE2
    issue_in && op == shift_unit_pkg::SHIFT_LEFT_IMM |=>
      dest_out.value == ($past(first_input) << $past(instr_in[10:6])))
    else $error("Immediate left shift result wrong.");
  a_sra_sign_fill: assert property (@(posedge clk_in) disable iff (rst_in) // RULE3
    issue_in && op == shift_unit_pkg::SHIFT_RIGHT_ARITH && first_input[31] |=>
      dest_out.value[31] == 1'b1)
    else $error("Arithmetic right shift lost the sign.");
  a_sra_count_low: assert property (@(posedge clk_in) disable iff (rst_in) // RULE4
    issue_in && op == shift_unit_pkg::SHIFT_RIGHT_ARITH |=>
      dest_out.value == 32'($signed($past(first_input)) >>> $past(second_input[4:0])))
    else $error("Arithmetic right shift used wrong count.");
  a_decode_shl_reg: assert property (@(posedge clk_in) disable iff (rst_in) // RULE5
    (op == shift_unit_pkg::SHIFT_LEFT_REG) |->
      instr_in[16:11] == 6'h13 && instr_in[10:6] == 5'h00 && instr_in[5:0] == 6'h3A)
    else $error("Register left shift decoded from wrong word.");
  a_decode_shl_imm: assert property (@(posedge clk_in) disable iff (rst_in) // RULE6
    (op == shift_unit_pkg::SHIFT_LEFT_IMM) |->
      instr_in[16:11] == 6'h12 && instr_in[26:22] == 5'h00 && instr_in[5:0] == 6'h3A)
    else $error("Immediate left shift decoded from wrong word.");
  a_decode_sra: assert property (@(posedge clk_in) disable iff (rst_in) // RULE7
    (op == shift_unit_pkg::SHIFT_RIGHT_ARITH) |->
      instr_in[16:11] == 6'h3B && instr_in[10:6] == 5'h00 && instr_in[5:0] == 6'h3A)
    else $error("Arithmetic right shift decoded from wrong word.");
  a_dest_index_valid: assert property (@(posedge clk_in) disable iff (rst_in) // RULE8
    accepted_out |=> dest_out.valid && dest_out.dest_index == $past(instr_in[21:17]))
    else $error("Result not delivered to destination.");

  a_refused_silent: assert property (@(posedge clk_in) disable iff (rst_in) // RULE5
    !accepted_out |=> !dest_out.valid)
    else $error("Result appeared for a refused word.");
  a_result_hold: assert property (@(posedge clk_in) disable iff (rst_in) // RULE8
    !accepted_out |=> $stable(dest_out.value) && $stable(dest_out.dest_index))
    else $error("Result changed without an accepted word.");
  a_valid_after_accept: assert property (@(posedge clk_in) disable iff (rst_in) // RULE8
    dest_out.valid |-> $past(accepted_out))
    else $error("Valid pulse without an accepted word.");
  a_accept_needs_issue: assert property (@(posedge clk_in) disable iff (rst_in) // RULE5
    accepted_out |-> issue_in)
    else $error("Word accepted without issue.");

  a_shl_reg_fill: assert property (@(posedge clk_in) disable iff (rst_in) // RULE1
    issue_in && op == shift_unit_pkg::SHIFT_LEFT_REG && second_input[4:0] != 5'h00 |=> dest_out.value[0] == 1'b0)
    else $error("Register left shift did not fill zeros.");
  a_shl_imm_fill: assert property (@(posedge clk_in) disable iff (rst_in) // RULE2
    issue_in && op == shift_unit_pkg::SHIFT_LEFT_IMM && instr_in[10:6] != 5'h00 |=> dest_out.value[0] == 1'b0)
    else $error("Immediate left shift did not fill zeros.");
  a_shl_full_shift: assert property (@(posedge clk_in) disable iff (rst_in) // RULE1
    issue_in && op == shift_unit_pkg::SHIFT_LEFT_REG && second_input[4:0] == 5'h1F |=> dest_out.value[30:0] == 31'h0)
    else $error("Register left shift by 31 kept low bits.");
  a_shl_reg_zero_count: assert property (@(posedge clk_in) disable iff (rst_in) // RULE1
    issue_in && op == shift_unit_pkg::SHIFT_LEFT_REG && second_input[4:0] == 5'h00 |=> dest_out.value == $past(first_input))
    else $error("Register left shift by zero changed the value.");
  a_shl_imm_zero_count: assert property (@(posedge clk_in) disable iff (rst_in) // RULE2
    issue_in && op == shift_unit_pkg::SHIFT_LEFT_IMM && instr_in[10:6] == 5'h00 |=> dest_out.value == $past(first_input))
    else $error("Immediate left shift by zero changed the value.");
  a_shl_reg_high_ignored: assert property (@(posedge clk_in) disable iff (rst_in) // RULE8
    issue_in && op == shift_unit_pkg::SHIFT_LEFT_REG |=>
      dest_out.value == ($past(first_input) << ($past(second_input) & 32'h0000_001F)))
    else $error("Register left shift used upper count bits.");

  a_sra_high_ignored: assert property (@(posedge clk_in) disable iff (rst_in) // RULE4
    issue_in && op == shift_unit_pkg::SHIFT_RIGHT_ARITH |=>
      dest_out.value == 32'($signed($past(first_input)) >>> ($past(second_input) & 32'h0000_001F)))
    else $error("Arithmetic right shift used upper count bits.");
  a_sra_positive_fill: assert property (@(posedge clk_in) disable iff (rst_in) // RULE3
    issue_in && op == shift_unit_pkg::SHIFT_RIGHT_ARITH && !first_input[31] && second_input[4:0] != 5'h00 |=>
      dest_out.value[31] == 1'b0)
    else $error("Arithmetic right shift of a positive value set the top bit.");
  a_sra_full_shift: assert property (@(posedge clk_in) disable iff (rst_in) // RULE3
    issue_in && op == shift_unit_pkg::SHIFT_RIGHT_ARITH && first_input[31] && second_input[4:0] == 5'h1F |=>
      dest_out.value == 32'hFFFF_FFFF)
    else $error("Arithmetic right shift by 31 of a negative value wrong.");
  a_sra_zero_count: assert property (@(posedge clk_in) disable iff (rst_in) // RULE3
    issue_in && op == shift_unit_pkg::SHIFT_RIGHT_ARITH && second_input[4:0] == 5'h00 |=> dest_out.value == $past(first_input))
    else $error("Arithmetic right shift by zero changed the value.");

  a_decode_wrong_op: assert property (@(posedge clk_in) disable iff (rst_in) // RULE5
    instr_in[5:0] != 6'h3A |-> op == shift_unit_pkg::SHIFT_NONE)
    else $error("Word with another primary opcode decoded as a shift.");
  a_decode_reg_mid: assert property (@(posedge clk_in) disable iff (rst_in) // RULE5
    instr_in[16:11] == 6'h13 && instr_in[10:6] != 5'h00 |-> op == shift_unit_pkg::SHIFT_NONE)
    else $error("Register left shift with nonzero middle field accepted.");
  a_decode_imm_b: assert property (@(posedge clk_in) disable iff (rst_in) // RULE6
    instr_in[16:11] == 6'h12 && instr_in[26:22] != 5'h00 |-> op == shift_unit_pkg::SHIFT_NONE)
    else $error("Immediate left shift with nonzero second index accepted.");
  a_decode_sra_mid: assert property (@(posedge clk_in) disable iff (rst_in) // RULE7
    instr_in[16:11] == 6'h3B && instr_in[10:6] != 5'h00 |-> op == shift_unit_pkg::SHIFT_NONE)
    else $error("Arithmetic right shift with nonzero middle field accepted.");
  a_decode_reg_hit: assert property (@(posedge clk_in) disable iff (rst_in) // RULE5
    instr_in[16:11] == 6'h13 && instr_in[10:6] == 5'h00 && instr_in[5:0] == 6'h3A |-> op == shift_unit_pkg::SHIFT_LEFT_REG)
    else $error("Register left shift word not decoded.");
  a_decode_imm_hit: assert property (@(posedge clk_in) disable iff (rst_in) // RULE6
    instr_in[16:11] == 6'h12 && instr_in[26:22] == 5'h00 && instr_in[5:0] == 6'h3A |-> op == shift_unit_pkg::SHIFT_LEFT_IMM)
    else $error("Immediate left shift word not decoded.");
  a_decode_sra_hit: assert property (@(posedge clk_in) disable iff (rst_in) // RULE7
    instr_in[16:11] == 6'h3B && instr_in[10:6] == 5'h00 && instr_in[5:0] == 6'h3A |-> op == shift_unit_pkg::SHIFT_RIGHT_ARITH)
    else $error("Arithmetic right shift word not decoded.");

endmodule : shift_left_and_arith_right_unit
`default_nettype wire

// [tb/instr_encoder.sv]
`timescale 1ns/100ps
`default_nettype none
module instr_encoder (
  input wire logic [1:0] kind_in,
  input wire logic [14:0] idx_in,
  input wire logic [4:0] count_in,
  output logic [31:0] instr_out
);
  logic [5:0] opx;
  logic imm;
  // Kind 3 is a rotate word, which this unit must refuse.
  always_comb begin
    case (kind_in)
      2'h0: opx = 6'h13;
      2'h1: opx = 6'h12;
      2'h2: opx = 6'h3B;
      default: opx = 6'h03;
    endcase
  end
  assign imm = (kind_in == 2'h1);
  assign instr_out = {idx_in[14:10], imm ? 5'h00 : idx_in[9:5], idx_in[4:0], opx, imm ? count_in : 5'h00, 6'h3A};
endmodule : instr_encoder
`default_nettype wire

// [tb/shift_left_and_arith_right_unit_test.sv]
`timescale 1ns/100ps
`default_nettype none
module shift_left_and_arith_right_unit_test;
  logic clk_in = 1'b0, rst_in = 1'b1, issue_in = 1'b0, accepted_out;
  logic [1:0] kind = 2'h0;
  logic [14:0] idx = 15'h0000;
  logic [4:0] cnt = 5'h00;
  logic [31:0] instr, a = 32'h0, b = 32'h0, rnd = 32'h687E, exp_val;
  logic [31:0] flip = 32'h0000_0000;
  shift_unit_pkg::shift_result_t dest_out;
  logic [36:0] notes[$];
  int miscompares = 0, checked = 0;
  instr_encoder enc (.kind_in(kind), .idx_in(idx), .count_in(cnt), .instr_out(instr));
  shift_left_and_arith_right_unit uut (.clk_in(clk_in), .rst_in(rst_in), .issue_in(issue_in), .instr_in(instr ^ flip),
    .first_input(a), .second_input(b), .dest_out(dest_out), .accepted_out(accepted_out));
  initial forever #25 clk_in = ~clk_in;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  // The count register gets random upper bits so that ignoring them is exercised.
  function automatic logic [31:0] expect_val(input logic [1:0] k, input logic [31:0] x, y, input logic [4:0] c);
    case (k)
      2'h0: return x << y[4:0];
      2'h1: return x << c;
      default: return $unsigned($signed(x) >>> y[4:0]);
    endcase
  endfunction : expect_val
  task automatic complete_run;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  always @(posedge clk_in) begin
    if (dest_out.valid === 1'b1) begin
      checked++;
      if (notes.size() == 0 || {dest_out.dest_index, dest_out.value} !== notes[0]) begin
        miscompares++;
        $display("[ERR] %0t result mismatch", $time);
      end
      if (notes.size() != 0) void'(notes.pop_front());
    end
  end
  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 600; i++) begin
      @(posedge clk_in);
      rnd = xs(rnd);
      kind <= rnd[1:0];
      idx <= rnd[16:2];
      cnt <= rnd[21:17];
      // Some words get a field broken so that every refusal path is reached.
      flip <= (rnd[26:24] == 3'h7) ? ((rnd[1:0] == 2'h1) ? 32'h0040_0000 : 32'h0000_0040) :
        ((rnd[26:24] == 3'h6) ? 32'h0000_0001 : 32'h0000_0000);
      issue_in <= rnd[22] | rnd[23];
      a <= {rnd[15:0], rnd[31:16]};
      b <= ~rnd;
      exp_val = expect_val(rnd[1:0], {rnd[15:0], rnd[31:16]}, ~rnd, rnd[21:17]);
      @(negedge clk_in);
      checked++;
      if (accepted_out !== (issue_in && kind != 2'h3 && flip == 32'h0)) begin
        miscompares++;
        $display("[ERR] %0t accept flag wrong", $time);
      end
      if (issue_in && kind != 2'h3 && flip == 32'h0) notes.push_back({idx[4:0], exp_val});
    end
    @(posedge clk_in);
    issue_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    checked++;
    if (notes.size() != 0) begin
      miscompares++;
      $display("[ERR] %0t results missing", $time);
    end
    $display("random shift test done");
    complete_run();
  end
endmodule : shift_left_and_arith_right_unit_test
`default_nettype wire
